// *** include/host_bus_if.sv ***
// pin-level bus between the host and the framer host port
`timescale 1ns/1ps
interface host_bus_if;
  logic bus_style_select;
  logic [9:0] addr;
  logic addr_latch;
  logic chip_sel_n;
  logic wr_rw_n;
  logic rd_data_strobe_n;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic int_oe;
  logic [7:0] data_bus;
  logic int_n;
  // wire level resolved from enables; undriven lines read as zero here
  assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'h00);
  assign int_n = ~int_oe;
  modport device (
    input bus_style_select, addr, addr_latch, chip_sel_n, wr_rw_n, rd_data_strobe_n,
    input data_bus,
    output dev_data_out, dev_data_oe, int_oe
  );
  modport host (
    output bus_style_select, addr, addr_latch, chip_sel_n, wr_rw_n, rd_data_strobe_n,
    output host_data_out, host_data_oe,
    input data_bus, int_n
  );
endinterface

// *** include/host_port_pkg.sv ***
// shared constants and types for the host bus port
package host_port_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int CHAN_MSB = 9;
  localparam int CHAN_LSB = 8;
  localparam int REG_MSB = 7;
  localparam int REG_LSB = 0;
  localparam int NUM_CHAN = 4;
  localparam int REGS_PER_CHAN = 256;
  localparam logic [1:0] ABSENT_CHAN = 2'h3;
  localparam logic [7:0] ID_OFFSET = 8'h00;
  localparam logic [7:0] ABSENT_READ = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] INT_SRC_OFFSET = 8'h06;
  localparam logic [7:0] INT_MASK_OFFSET = 8'h09;
  // identity value is arbitrary
  localparam logic [7:0] DEVICE_ID = 8'h5A;
  localparam logic STYLE_SEPARATE = 1'b0;
  localparam logic STYLE_DATA_STROBE = 1'b1;
  // host-side strobe length in clock cycles
  localparam int STROBE_CYCLES = 4;
  localparam logic [2:0] STROBE_CNT = 3'(STROBE_CYCLES);
  typedef enum logic [1:0] {
    H_IDLE,
    H_ADDR,
    H_STROBE,
    H_DONE
  } host_state_e;
endpackage

// *** verification/host_bus_props.sv ***
// assertions on the host bus between the two ends
`timescale 1ns/1ps
module host_bus_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic bus_style_select,
  input wire logic addr_latch,
  input wire logic chip_sel_n,
  input wire logic wr_rw_n,
  input wire logic rd_data_strobe_n,
  input wire logic dev_data_oe,
  input wire logic host_data_oe,
  input wire logic int_oe
);
  // ----
  // bus properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic rd_c;
  logic wr_c;
  logic stb_c;
  logic [1:0] wr_cnt_q;
  logic [1:0] wr_cnt_d;
  assign rd_c = !chip_sel_n && !rd_data_strobe_n && (!bus_style_select || wr_rw_n);
  assign wr_c = !chip_sel_n && !wr_rw_n && (!bus_style_select || !rd_data_strobe_n);
  assign stb_c = !rd_data_strobe_n || (!bus_style_select && !wr_rw_n);
  // writes commit just after the strobe, so servicing shows within three edges
  always_comb begin
    wr_cnt_d = wr_c ? 2'h3 : (wr_cnt_q == 2'h0 ? 2'h0 : wr_cnt_q - 2'h1);
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) wr_cnt_q <= 2'h0;
    else wr_cnt_q <= wr_cnt_d;
  end
  oe_read_a: assert property (dev_data_oe |-> rd_c)
    else $error("data driven outside a read");
  read_drive_a: assert property (rd_c ##1 rd_c |-> dev_data_oe)
    else $error("read strobe not answered");
  no_fight_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
  host_drive_a: assert property (host_data_oe |-> !rd_c)
    else $error("host drives data in a read");
  strobe_len_a: assert property ($fell(chip_sel_n) |-> !stb_c ##1 stb_c [*4] ##1 !stb_c)
    else $error("strobe not framed by select");
  one_strobe_a: assert property (!bus_style_select |-> rd_data_strobe_n || wr_rw_n)
    else $error("two strobes at once");
  strobe_cs_a: assert property (stb_c |-> !chip_sel_n)
    else $error("strobe without select");
  int_hold_a: assert property ($fell(int_oe) |-> wr_cnt_q != 2'h0)
    else $error("interrupt dropped unserviced");
  cover property (rd_c && bus_style_select);
  cover property (wr_c && !bus_style_select);
  cover property ($fell(int_oe));
  cover property ($fell(addr_latch));
endmodule // host_bus_props

// *** verification/host_cpu_bus_port_tb.sv ***
// self-checking bench joining the host master and the framer port
`timescale 1ns/1ps
module host_cpu_bus_port_tb;
  logic ref_clk;
  logic resetn;
  logic style;
  logic muxed;
  logic req;
  logic req_write;
  logic [9:0] req_addr;
  logic [7:0] req_wdata;
  logic busy;
  logic done;
  logic [7:0] rdata;
  logic irq;
  logic four_channels;
  logic [3:0] event_in;
  logic [3:0] event_pending;
  int failures = 0;
  int check_count = 0;
  host_bus_if bus_if();
  framer_host_port framer_host_port_inst (.ref_clk(ref_clk), .resetn(resetn), .bus(bus_if),
    .four_channels(four_channels), .event_in(event_in), .event_pending(event_pending));
  host_cpu_master host_cpu_master_inst (.ref_clk(ref_clk), .resetn(resetn), .bus(bus_if),
    .style(style), .muxed(muxed), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata), .irq(irq));
  host_bus_props host_bus_props_inst (.ref_clk(ref_clk), .resetn(resetn),
    .bus_style_select(bus_if.bus_style_select), .addr_latch(bus_if.addr_latch),
    .chip_sel_n(bus_if.chip_sel_n), .wr_rw_n(bus_if.wr_rw_n),
    .rd_data_strobe_n(bus_if.rd_data_strobe_n), .dev_data_oe(bus_if.dev_data_oe),
    .host_data_oe(bus_if.host_data_oe), .int_oe(bus_if.int_oe));
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req = 1'h1;
    @(negedge ref_clk);
    req = 1'h0;
    chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'h1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    // idle cycle keeps back-to-back writes apart
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    acc(1'h0, a, 8'h00);
    chk("rdata", e, rdata);
  endtask
  task automatic t_id();
    for (int i = 0; i < 16; i++) begin
      style = i[3];
      muxed = i[2];
      rd({i[1:0], host_port_pkg::ID_OFFSET}, host_port_pkg::DEVICE_ID);
    end
    $display("test id done");
  endtask
  task automatic t_rw();
    for (int s = 0; s < 4; s++) begin
      style = s[0];
      muxed = s[1];
      acc(1'h1, 10'h101, 8'hC1 ^ 8'(s));
      acc(1'h1, 10'h201, 8'h3A);
      acc(1'h1, 10'h200, 8'hFF);
      rd(10'h101, 8'hC1 ^ 8'(s));
      rd(10'h201, 8'h3A);
      rd(10'h200, host_port_pkg::DEVICE_ID);
    end
    rd(10'h001, host_port_pkg::REG_RESET);
    four_channels = 1'h0;
    acc(1'h1, 10'h302, 8'h77);
    rd(10'h302, host_port_pkg::ABSENT_READ);
    four_channels = 1'h1;
    rd(10'h302, host_port_pkg::REG_RESET);
    acc(1'h1, 10'h302, 8'h77);
    rd(10'h302, 8'h77);
    $display("test access done");
  endtask
  task automatic t_irq();
    acc(1'h1, 10'h009, 8'h01);
    event_in = 4'h1;
    @(negedge ref_clk);
    event_in = 4'h0;
    repeat (10) @(negedge ref_clk);
    chk("irq", 8'h01, {7'h00, irq});
    chk("int_n", 8'h00, {7'h00, bus_if.int_n});
    acc(1'h1, 10'h006, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    event_in = 4'h2;
    @(negedge ref_clk);
    event_in = 4'h0;
    @(negedge ref_clk);
    chk("pending", 8'h02, {4'h0, event_pending});
    chk("irq", 8'h00, {7'h00, irq});
    acc(1'h1, 10'h009, 8'h03);
    chk("irq", 8'h01, {7'h00, irq});
    acc(1'h1, 10'h009, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test interrupt done");
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    ref_clk = 1'h0;
    // one ungapped 50 MHz clock stands in for both system and line clock
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    resetn = 1'h0;
    style = 1'h0;
    muxed = 1'h0;
    req = 1'h0;
    req_write = 1'h0;
    req_addr = 10'h000;
    req_wdata = 8'h00;
    four_channels = 1'h1;
    event_in = 4'h0;
    repeat (8) @(negedge ref_clk);
    resetn = 1'h1;
    @(negedge ref_clk);
    t_id();
    t_rw();
    t_irq();
    stop_test();
  end
endmodule // host_cpu_bus_port_tb

// *** verilog/framer_host_port.sv ***
// device end: framer host bus port with register windows and interrupt
`timescale 1ns/1ps
module framer_host_port (
  input wire logic ref_clk,
  input wire logic resetn,
  host_bus_if.device bus,
  input wire logic four_channels,
  input wire logic [3:0] event_in,
  output logic [3:0] event_pending
);
  // ----------------------------------------------------------------
  // address latch
  // ----------------------------------------------------------------
  logic [9:0] addr_hold_q, addr_hold_d;
  logic [9:0] cur_addr;
  always_comb begin
    addr_hold_d = addr_hold_q;
    if (bus.addr_latch) begin
      addr_hold_d = bus.addr;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addr_hold_q <= 10'h000;
    end else begin
      addr_hold_q <= addr_hold_d;
    end
  end
  // transparent while high, hold after the fall
  assign cur_addr = bus.addr_latch ? bus.addr : addr_hold_q;
  logic [1:0] chan;
  logic [7:0] reg_off;
  assign chan = cur_addr[host_port_pkg::CHAN_MSB:host_port_pkg::CHAN_LSB];
  assign reg_off = cur_addr[host_port_pkg::REG_MSB:host_port_pkg::REG_LSB];
  logic absent;
  assign absent = !four_channels && (chan == host_port_pkg::ABSENT_CHAN);

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  logic rd_act, wr_act;
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (!bus.chip_sel_n) begin
      if (bus.bus_style_select == host_port_pkg::STYLE_SEPARATE) begin
        rd_act = !bus.rd_data_strobe_n;
        wr_act = !bus.wr_rw_n && bus.rd_data_strobe_n;
      end else begin
        rd_act = !bus.rd_data_strobe_n && bus.wr_rw_n;
        wr_act = !bus.rd_data_strobe_n && !bus.wr_rw_n;
      end
    end
  end
  // write commits once per strobe to a present channel, one clock after its trailing edge, when data is settled
  logic wr_prev_q, wr_prev_d;
  logic [9:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic wr_absent_q, wr_absent_d;
  logic commit;
  always_comb begin
    wr_prev_d = wr_act;
    wr_addr_d = wr_act ? cur_addr : wr_addr_q;
    wr_data_d = wr_act ? bus.data_bus : wr_data_q;
    wr_absent_d = wr_act ? absent : wr_absent_q;
  end
  assign commit = wr_prev_q && !wr_act && !wr_absent_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_prev_q <= 1'b0;
      wr_addr_q <= 10'h000;
      wr_data_q <= 8'h00;
      wr_absent_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_prev_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      wr_absent_q <= wr_absent_d;
    end
  end

  // ----------------------------------------------------------------
  // register windows
  // ----------------------------------------------------------------
  logic [7:0] regs_q [host_port_pkg::NUM_CHAN][host_port_pkg::REGS_PER_CHAN];
  logic [1:0] wch;
  logic [7:0] woff;
  assign wch = wr_addr_q[host_port_pkg::CHAN_MSB:host_port_pkg::CHAN_LSB];
  assign woff = wr_addr_q[host_port_pkg::REG_MSB:host_port_pkg::REG_LSB];
  // interrupt sources and masks are written in channel zero, sources read at offset 6 of every present channel; sources set, writing 1 clears
  logic [3:0] src_q, src_d;
  logic [3:0] mask_q, mask_d;
  logic wr_src, wr_mask;
  assign wr_src = commit && (wch == 2'h0) && (woff == host_port_pkg::INT_SRC_OFFSET);
  assign wr_mask = commit && (wch == 2'h0) && (woff == host_port_pkg::INT_MASK_OFFSET);
  always_comb begin
    src_d = src_q;
    mask_d = mask_q;
    if (wr_src) begin
      src_d = src_q & ~wr_data_q[3:0];
    end
    src_d = src_d | event_in; // set wins over clear
    if (wr_mask) begin
      mask_d = wr_data_q[3:0];
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_q <= 4'h0;
      mask_q <= 4'h0;
    end else begin
      src_q <= src_d;
      mask_q <= mask_d;
    end
  end
  // cleared on reset so unwritten registers read their default; costs flops, not a ram
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < host_port_pkg::NUM_CHAN; c++) begin
        for (int r = 0; r < host_port_pkg::REGS_PER_CHAN; r++) begin
          regs_q[c][r] <= host_port_pkg::REG_RESET;
        end
      end
    end else if (commit) begin
      regs_q[wch][woff] <= wr_data_q;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_q, rd_d;
  logic oe_q, oe_d;
  always_comb begin
    rd_d = host_port_pkg::REG_RESET;
    if (absent) begin
      rd_d = host_port_pkg::ABSENT_READ;
    end else if (reg_off == host_port_pkg::ID_OFFSET) begin
      rd_d = host_port_pkg::DEVICE_ID;
    end else if (reg_off == host_port_pkg::INT_SRC_OFFSET) begin
      rd_d = {4'h0, src_q};
    end else if (reg_off == host_port_pkg::INT_MASK_OFFSET && chan == 2'h0) begin
      rd_d = {4'h0, mask_q};
    end else begin
      rd_d = regs_q[chan][reg_off];
    end
    oe_d = rd_act;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      oe_q <= oe_d;
    end
  end
  // release immediately when strobe or select drops to avoid contention
  assign bus.dev_data_oe = oe_q && rd_act;
  assign bus.dev_data_out = rd_q;

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  assign bus.int_oe = |(src_q & mask_q);
  assign event_pending = src_q;
endmodule // framer_host_port

// *** verilog/host_cpu_master.sv ***
// host end: cpu bus master issuing single register accesses
`timescale 1ns/1ps
module host_cpu_master (
  input wire logic ref_clk,
  input wire logic resetn,
  host_bus_if.host bus,
  input wire logic style,
  input wire logic muxed,
  input wire logic req,
  input wire logic req_write,
  input wire logic [9:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic irq
);
  host_port_pkg::host_state_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [9:0] a_q, a_d;
  logic [7:0] wd_q, wd_d, rd_q, rd_d;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    a_d = a_q;
    wd_d = wd_q;
    rd_d = rd_q;
    unique case (st_q)
      host_port_pkg::H_IDLE: begin
        if (req) begin
          wr_d = req_write;
          a_d = req_addr;
          wd_d = req_wdata;
          st_d = host_port_pkg::H_ADDR;
        end
      end
      host_port_pkg::H_ADDR: begin
        cnt_d = host_port_pkg::STROBE_CNT;
        st_d = host_port_pkg::H_STROBE;
      end
      host_port_pkg::H_STROBE: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          rd_d = bus.data_bus;
          st_d = host_port_pkg::H_DONE;
        end
      end
      host_port_pkg::H_DONE: begin
        st_d = host_port_pkg::H_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= host_port_pkg::H_IDLE;
      cnt_q <= 3'h0;
      wr_q <= 1'b0;
      a_q <= 10'h000;
      wd_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      a_q <= a_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
    end
  end
  logic in_addr, in_strobe, active;
  assign in_addr = (st_q == host_port_pkg::H_ADDR);
  assign in_strobe = (st_q == host_port_pkg::H_STROBE);
  assign active = in_addr || in_strobe;
  assign bus.bus_style_select = style;
  assign bus.addr = a_q;
  // multiplexed: latch high only in address phase, falls on the same edge the strobe asserts
  assign bus.addr_latch = muxed ? in_addr : 1'b1;
  assign bus.chip_sel_n = !active;
  always_comb begin
    if (style == host_port_pkg::STYLE_SEPARATE) begin
      bus.wr_rw_n = !(in_strobe && wr_q);
      bus.rd_data_strobe_n = !(in_strobe && !wr_q);
    end else begin
      bus.wr_rw_n = !wr_q;
      bus.rd_data_strobe_n = !in_strobe;
    end
  end
  // muxed bus carries address on data lines in address phase
  assign bus.host_data_oe = (in_addr && muxed) || (in_strobe && wr_q);
  assign bus.host_data_out = in_addr ? a_q[7:0] : wd_q;
  assign busy = (st_q != host_port_pkg::H_IDLE);
  assign done = (st_q == host_port_pkg::H_DONE);
  assign rdata = rd_q;
  assign irq = !bus.int_n;
endmodule // host_cpu_master
